// [core/cssfr_map.svh]
// Register indices, reset values, field positions and codes of the core register block
`ifndef CSSFR_MAP_SVH
`define CSSFR_MAP_SVH
// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define CSSFR_IDX_STACK 8'h81
`define CSSFR_IDX_P0_LOW 8'h82
`define CSSFR_IDX_P0_HIGH 8'h83
`define CSSFR_IDX_P1_LOW 8'h84
`define CSSFR_IDX_P1_HIGH 8'h85
`define CSSFR_IDX_PAGE 8'h86
`define CSSFR_IDX_IFCTRL 8'h8F
`define CSSFR_IDX_MISC 8'h91
`define CSSFR_IDX_STATUS 8'hD0
`define CSSFR_IDX_PRIMARY 8'hE0
`define CSSFR_IDX_SECOND 8'hF0
// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define CSSFR_RST_STACK 8'h07
`define CSSFR_RST_BYTE 8'h00
`define CSSFR_RST_WORD 16'h0000
// ---------------------------------------------------------------
// Field positions and masks
// ---------------------------------------------------------------
`define CSSFR_ST_PARITY 0
`define CSSFR_ST_BANK_LO 3
`define CSSFR_ST_BANK_HI 4
`define CSSFR_IF_SELF_PROG 0
`define CSSFR_IF_XRAM_DIS 1
`define CSSFR_IF_LATCH_LO 2
`define CSSFR_IF_LATCH_HI 3
`define CSSFR_IF_CODE_LOCK 6
`define CSSFR_IF_TIMING 7
`define CSSFR_IF_WMASK 8'h8F
`define CSSFR_MISC_SEL 0
`define CSSFR_MISC_WMASK 8'hBF
// ---------------------------------------------------------------
// Codes and limits
// ---------------------------------------------------------------
`define CSSFR_LATCH_ALWAYS 2'b00
`define CSSFR_LATCH_NEVER 2'b01
`define CSSFR_LATCH_EXT 2'b10
`define CSSFR_XRAM_PAGES 8'h04
`define CSSFR_XRAM_LIMIT 16'h0800
`define CSSFR_STEP_BYTE 8'h01
`define CSSFR_STEP_WORD 16'h0001
`define CSSFR_RESP_OKAY 2'b00
`define CSSFR_RESP_SLVERR 2'b10
`endif

// [core/cssfr_pkg.sv]
// Types shared by the core register block
package cssfr_pkg;
   typedef struct packed {
      logic push;
      logic pop;
      logic primary_load;
      logic [7:0] primary_val;
      logic status_load;
      logic [7:0] status_val;
      logic second_load;
      logic [7:0] second_val;
      logic ptr_load;
      logic [15:0] ptr_val;
      logic ptr_inc;
      logic [2:0] reg_sel;
      logic movx_ri;
      logic movx_ptr;
      logic [7:0] ri_val;
   } cssfr_core_req_s;
   typedef struct packed {
      logic [7:0] primary;
      logic [7:0] second;
      logic [7:0] status;
      logic [7:0] stack_top;
      logic [7:0] stack_wr_addr;
      logic [7:0] stack_rd_addr;
      logic [7:0] work_reg_addr;
      logic [15:0] active_ptr;
   } cssfr_core_view_s;
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] port2_hi;
      logic xram_sel;
      logic ext_cycle;
      logic ale_enable;
      logic one_t_mode;
      logic self_prog_en;
   } cssfr_xmem_s;
endpackage

// [core/cssfr_top.sv]
// Core special-function register block with AXI4-Lite access
//
// Function
// - Stack pointer is 8 bits, resets 07h
// - Push increments stack pointer before writing
// - Bank select maps R0-R7 onto banks
// - Parity bit tracks accumulator ones, even parity
// - Select bit one picks second pointer
// - Pointer instructions use selected pointer
// - Pointer loads whole or by byte
// - Page register gives MOVX Ri high byte while disable bit clear
// - Timing bit zero 2T, one 1T
// - Latch strobe code: always, never, external only
// - Disable bit sends data moves off chip
// - Self programming enabled only when bit set
// - Code lock bit is read only
// - Expanded RAM reached only by MOVX
// - Port 2 gets page or latch byte
`timescale 1ns/1ps
`include "cssfr_map.svh"
module cssfr_top
   import cssfr_pkg::*;
#(
   parameter int ADDR_W = 10
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // AXI4-Lite write address
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Core side
   input wire cssfr_core_req_s core_req,
   output cssfr_core_view_s core_view,
   // External memory side
   input wire logic [7:0] port2_latch,
   input wire logic code_lock_in,
   output cssfr_xmem_s xmem
);
   // ---------------------------------------------------------------
   // Register storage
   // ---------------------------------------------------------------
   logic [7:0] stack_top_pointer_reg;
   logic [7:0] stack_top_pointer_next;
   logic [7:0] pointer0_low_byte_reg;
   logic [7:0] pointer0_high_byte_reg;
   logic [7:0] pointer1_low_byte_reg;
   logic [7:0] pointer1_high_byte_reg;
   logic [15:0] ptr0_next;
   logic [15:0] ptr1_next;
   logic [7:0] movx_page_reg;
   logic [7:0] interface_ctrl_reg;
   logic [7:0] misc_control_reg;
   logic [7:0] status_word_reg;
   logic [7:0] status_word_next;
   logic [7:0] primary_operand_reg;
   logic [7:0] primary_operand_next;
   logic [7:0] second_operand_reg;
   logic [7:0] second_operand_next;
   logic code_lock_reg;

   // ---------------------------------------------------------------
   // AXI4-Lite handshake state
   // ---------------------------------------------------------------
   logic aw_held_reg;
   logic [7:0] aw_idx_reg;
   logic w_held_reg;
   logic [7:0] w_data_reg;
   logic w_lane_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic [7:0] rd_byte;
   logic rd_hit;

   wire aw_fire = s_axi_awvalid & s_axi_awready;
   wire w_fire = s_axi_wvalid & s_axi_wready;
   wire ar_fire = s_axi_arvalid & s_axi_arready;
   wire wr_go = aw_held_reg & w_held_reg & ~bvalid_reg;
   wire wr_en = wr_go & w_lane_reg;
   wire [7:0] ar_idx = s_axi_araddr[9:2];

   assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
   assign s_axi_wready = ~w_held_reg & ~bvalid_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = ~rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   // ---------------------------------------------------------------
   // Write address decode
   // ---------------------------------------------------------------
   wire hit_stack = aw_idx_reg == `CSSFR_IDX_STACK;
   wire hit_p0_low = aw_idx_reg == `CSSFR_IDX_P0_LOW;
   wire hit_p0_high = aw_idx_reg == `CSSFR_IDX_P0_HIGH;
   wire hit_p1_low = aw_idx_reg == `CSSFR_IDX_P1_LOW;
   wire hit_p1_high = aw_idx_reg == `CSSFR_IDX_P1_HIGH;
   wire hit_page = aw_idx_reg == `CSSFR_IDX_PAGE;
   wire hit_ifctrl = aw_idx_reg == `CSSFR_IDX_IFCTRL;
   wire hit_misc = aw_idx_reg == `CSSFR_IDX_MISC;
   wire hit_status = aw_idx_reg == `CSSFR_IDX_STATUS;
   wire hit_primary = aw_idx_reg == `CSSFR_IDX_PRIMARY;
   wire hit_second = aw_idx_reg == `CSSFR_IDX_SECOND;
   wire wr_hit = hit_stack | hit_p0_low | hit_p0_high | hit_p1_low | hit_p1_high
      | hit_page | hit_ifctrl | hit_misc | hit_status | hit_primary | hit_second;

   // ---------------------------------------------------------------
   // Derived control fields
   // ---------------------------------------------------------------
   wire pointer_select = misc_control_reg[`CSSFR_MISC_SEL];
   wire [1:0] bank_select = status_word_reg[`CSSFR_ST_BANK_HI:`CSSFR_ST_BANK_LO];
   wire [1:0] latch_strobe_control =
      interface_ctrl_reg[`CSSFR_IF_LATCH_HI:`CSSFR_IF_LATCH_LO];
   wire internal_xram_disable = interface_ctrl_reg[`CSSFR_IF_XRAM_DIS];
   wire self_program_enable = interface_ctrl_reg[`CSSFR_IF_SELF_PROG];
   wire timing_one_t = interface_ctrl_reg[`CSSFR_IF_TIMING];
   wire [15:0] data_pointer_zero = {pointer0_high_byte_reg, pointer0_low_byte_reg};
   wire [15:0] data_pointer_one = {pointer1_high_byte_reg, pointer1_low_byte_reg};
   wire parity_bit = ^primary_operand_reg;
   wire [7:0] status_view = {status_word_reg[7:1], parity_bit};
   wire [7:0] ifctrl_view = {interface_ctrl_reg[7], code_lock_reg, 2'b00,
      interface_ctrl_reg[3:0]};

   // ---------------------------------------------------------------
   // Stack pointer
   // ---------------------------------------------------------------
   // pre-increment on push
   wire [7:0] stack_inc = 8'(stack_top_pointer_reg + `CSSFR_STEP_BYTE);
   wire [7:0] stack_dec = 8'(stack_top_pointer_reg - `CSSFR_STEP_BYTE);
   always_comb begin
      stack_top_pointer_next = stack_top_pointer_reg;
      if (core_req.push) begin
         stack_top_pointer_next = stack_inc;
      end else if (core_req.pop) begin
         stack_top_pointer_next = stack_dec;
      end else if (wr_en & hit_stack) begin
         stack_top_pointer_next = w_data_reg;
      end
   end

   // ---------------------------------------------------------------
   // Data pointers
   // ---------------------------------------------------------------
   // operations on selected pointer
   wire [15:0] active_ptr = pointer_select ? data_pointer_one : data_pointer_zero;
   wire [15:0] active_inc = 16'(active_ptr + `CSSFR_STEP_WORD);
   wire [15:0] core_ptr = core_req.ptr_load ? core_req.ptr_val : active_inc;
   wire core_ptr_op = core_req.ptr_load | core_req.ptr_inc;
   always_comb begin
      ptr0_next = data_pointer_zero;
      ptr1_next = data_pointer_one;
      if (core_ptr_op & ~pointer_select) begin
         ptr0_next = core_ptr;
      end else if (wr_en & hit_p0_low) begin
         ptr0_next[7:0] = w_data_reg;
      end else if (wr_en & hit_p0_high) begin
         ptr0_next[15:8] = w_data_reg;
      end
      if (core_ptr_op & pointer_select) begin
         ptr1_next = core_ptr;
      end else if (wr_en & hit_p1_low) begin
         ptr1_next[7:0] = w_data_reg;
      end else if (wr_en & hit_p1_high) begin
         ptr1_next[15:8] = w_data_reg;
      end
   end

   // ---------------------------------------------------------------
   // Accumulator, second operand, status word
   // ---------------------------------------------------------------
   always_comb begin
      primary_operand_next = primary_operand_reg;
      second_operand_next = second_operand_reg;
      status_word_next = status_word_reg;
      if (core_req.primary_load) begin
         primary_operand_next = core_req.primary_val;
      end else if (wr_en & hit_primary) begin
         primary_operand_next = w_data_reg;
      end
      if (core_req.second_load) begin
         second_operand_next = core_req.second_val;
      end else if (wr_en & hit_second) begin
         second_operand_next = w_data_reg;
      end
      if (core_req.status_load) begin
         status_word_next = core_req.status_val;
      end else if (wr_en & hit_status) begin
         status_word_next = w_data_reg;
      end
      status_word_next[`CSSFR_ST_PARITY] = 1'b0;
   end

   // ---------------------------------------------------------------
   // Register update
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         stack_top_pointer_reg <= `CSSFR_RST_STACK;
         {pointer0_high_byte_reg, pointer0_low_byte_reg} <= `CSSFR_RST_WORD;
         {pointer1_high_byte_reg, pointer1_low_byte_reg} <= `CSSFR_RST_WORD;
         movx_page_reg <= `CSSFR_RST_BYTE;
         interface_ctrl_reg <= `CSSFR_RST_BYTE;
         misc_control_reg <= `CSSFR_RST_BYTE;
         status_word_reg <= `CSSFR_RST_BYTE;
         primary_operand_reg <= `CSSFR_RST_BYTE;
         second_operand_reg <= `CSSFR_RST_BYTE;
         code_lock_reg <= 1'b0;
      end else begin
         stack_top_pointer_reg <= stack_top_pointer_next;
         {pointer0_high_byte_reg, pointer0_low_byte_reg} <= ptr0_next;
         {pointer1_high_byte_reg, pointer1_low_byte_reg} <= ptr1_next;
         primary_operand_reg <= primary_operand_next;
         second_operand_reg <= second_operand_next;
         status_word_reg <= status_word_next;
         code_lock_reg <= code_lock_in;
         if (wr_en & hit_page) begin
            movx_page_reg <= w_data_reg;
         end
         if (wr_en & hit_ifctrl) begin
            interface_ctrl_reg <= w_data_reg & `CSSFR_IF_WMASK;
         end
         if (wr_en & hit_misc) begin
            misc_control_reg <= w_data_reg & `CSSFR_MISC_WMASK;
         end
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite write channel
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         aw_held_reg <= 1'b0;
         aw_idx_reg <= `CSSFR_RST_BYTE;
         w_held_reg <= 1'b0;
         w_data_reg <= `CSSFR_RST_BYTE;
         w_lane_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= `CSSFR_RESP_OKAY;
      end else begin
         if (aw_fire) begin
            aw_held_reg <= 1'b1;
            aw_idx_reg <= s_axi_awaddr[9:2];
         end
         if (w_fire) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata[7:0];
            w_lane_reg <= s_axi_wstrb[0];
         end
         if (wr_go) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? `CSSFR_RESP_OKAY : `CSSFR_RESP_SLVERR;
         end else if (bvalid_reg & s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Read decode
   // ---------------------------------------------------------------
   always_comb begin
      rd_byte = `CSSFR_RST_BYTE;
      rd_hit = 1'b1;
      if (ar_idx == `CSSFR_IDX_STACK) begin
         rd_byte = stack_top_pointer_reg;
      end else if (ar_idx == `CSSFR_IDX_P0_LOW) begin
         rd_byte = pointer0_low_byte_reg;
      end else if (ar_idx == `CSSFR_IDX_P0_HIGH) begin
         rd_byte = pointer0_high_byte_reg;
      end else if (ar_idx == `CSSFR_IDX_P1_LOW) begin
         rd_byte = pointer1_low_byte_reg;
      end else if (ar_idx == `CSSFR_IDX_P1_HIGH) begin
         rd_byte = pointer1_high_byte_reg;
      end else if (ar_idx == `CSSFR_IDX_PAGE) begin
         rd_byte = movx_page_reg;
      end else if (ar_idx == `CSSFR_IDX_IFCTRL) begin
         rd_byte = ifctrl_view;
      end else if (ar_idx == `CSSFR_IDX_MISC) begin
         rd_byte = misc_control_reg;
      end else if (ar_idx == `CSSFR_IDX_STATUS) begin
         rd_byte = status_view;
      end else if (ar_idx == `CSSFR_IDX_PRIMARY) begin
         rd_byte = primary_operand_reg;
      end else if (ar_idx == `CSSFR_IDX_SECOND) begin
         rd_byte = second_operand_reg;
      end else begin
         rd_hit = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite read channel
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= `CSSFR_RESP_OKAY;
      end else if (ar_fire) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= {24'h000000, rd_byte};
         rresp_reg <= rd_hit ? `CSSFR_RESP_OKAY : `CSSFR_RESP_SLVERR;
      end else if (rvalid_reg & s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // External data move addressing
   // ---------------------------------------------------------------
   // port 2 high byte source
   wire page_internal = movx_page_reg < `CSSFR_XRAM_PAGES;
   wire [7:0] ri_high = internal_xram_disable ? port2_latch : movx_page_reg;
   // page, or port 2 latch when disable bit set, forms MOVX Ri upper byte
   wire [15:0] movx_addr = core_req.movx_ptr ? active_ptr
      : {ri_high, core_req.ri_val};
   wire movx_any = core_req.movx_ri | core_req.movx_ptr;
   wire xram_sel = movx_any & ~internal_xram_disable & (movx_addr < `CSSFR_XRAM_LIMIT);
   wire ext_cycle = movx_any & ~xram_sel;
   wire ale_enable = (latch_strobe_control == `CSSFR_LATCH_ALWAYS)
      | ((latch_strobe_control == `CSSFR_LATCH_EXT) & ext_cycle);

   // ---------------------------------------------------------------
   // Output assembly
   // ---------------------------------------------------------------
   assign core_view.primary = primary_operand_reg;
   assign core_view.second = second_operand_reg;
   assign core_view.status = status_view;
   assign core_view.stack_top = stack_top_pointer_reg;
   assign core_view.stack_wr_addr = stack_inc;
   assign core_view.stack_rd_addr = stack_top_pointer_reg;
   assign core_view.work_reg_addr = {3'b000, bank_select, core_req.reg_sel};
   assign core_view.active_ptr = active_ptr;
   assign xmem.addr = movx_addr;
   assign xmem.port2_hi = ri_high;
   assign xmem.xram_sel = xram_sel;
   assign xmem.ext_cycle = ext_cycle;
   assign xmem.ale_enable = ale_enable;
   assign xmem.one_t_mode = timing_one_t;
   assign xmem.self_prog_en = self_program_enable;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   stack_reset_a: assert property (@(posedge sys_clk) sys_rst |=>
      stack_top_pointer_reg == `CSSFR_RST_STACK) else $error("stack reset wrong");
   push_inc_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      core_req.push |->
      core_view.stack_wr_addr == 8'(stack_top_pointer_reg + 8'h01))
      else $error("push not pre-incremented");
   push_store_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      core_req.push |=> stack_top_pointer_reg == 8'($past(stack_top_pointer_reg) + 8'h01))
      else $error("push did not step pointer");
   bank_map_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      core_view.work_reg_addr == {3'b000, status_word_reg[4:3], core_req.reg_sel})
      else $error("bank mapping wrong");
   parity_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      core_req.primary_load |=> core_view.status[0] == ^$past(core_req.primary_val))
      else $error("parity wrong");
   ptr_sel_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      core_view.active_ptr == (misc_control_reg[0] ? data_pointer_one : data_pointer_zero))
      else $error("pointer select wrong");
   ptr_inc_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      core_req.ptr_inc & ~core_req.ptr_load |=>
      core_view.active_ptr == 16'($past(core_view.active_ptr) + 16'h0001))
      else $error("pointer increment wrong");
   ptr_load_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      core_req.ptr_load |=> core_view.active_ptr == $past(core_req.ptr_val))
      else $error("pointer load wrong");
   page_hi_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      core_req.movx_ri & ~core_req.movx_ptr |-> xmem.addr[15:8] ==
      (interface_ctrl_reg[1] ? port2_latch : movx_page_reg)) else $error("page byte wrong");
   ale_gate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      latch_strobe_control == 2'b01 |-> ~xmem.ale_enable) else $error("strobe not suppressed");
   xram_dis_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      interface_ctrl_reg[1] |-> ~xmem.xram_sel) else $error("disabled RAM selected");
   xram_movx_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      xmem.xram_sel |-> movx_any & page_internal | core_req.movx_ptr)
      else $error("RAM selected without move");
   lock_ro_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      wr_en & hit_ifctrl |=> ifctrl_view[6] == $past(code_lock_in))
      else $error("lock bit writable");
   unused_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      ifctrl_view[5:4] == 2'b00 && misc_control_reg[6] == 1'b0)
      else $error("unused bits not zero");
   timing_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
      wr_en & hit_ifctrl |=> xmem.one_t_mode == $past(w_data_reg[7]))
      else $error("timing mode wrong");
endmodule

// [sim/test_cssfr_top.sv]
// Self-checking bench for the core register block
`timescale 1ns/1ps
`include "cssfr_map.svh"
module test_cssfr_top;
   import cssfr_pkg::*;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic sys_clk = 0, sys_rst = 1;
   logic [9:0] awaddr = '0, araddr = '0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [31:0] wdata = '0, rdata, s = 32'd23888;
   logic [3:0] wstrb = 4'hF;
   logic [1:0] bresp, rresp;
   cssfr_core_req_s core_req = '0;
   cssfr_core_view_s core_view;
   cssfr_xmem_s xmem;
   logic [7:0] port2_latch = 8'h00, v;
   logic code_lock_in = 0;
   logic [15:0] dp;
   logic [9:0] exp_q[$];
   logic [7:0] u_idx[4] = '{`CSSFR_IDX_PAGE, `CSSFR_IDX_P1_HIGH, `CSSFR_IDX_SECOND,
      `CSSFR_IDX_IFCTRL};
   int err_total = 0, checks = 0;
   cssfr_top u_cssfr_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .core_req(core_req), .core_view(core_view),
      .port2_latch(port2_latch), .code_lock_in(code_lock_in), .xmem(xmem));
   initial forever #10 sys_clk = ~sys_clk;
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] xs();
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] want);
      checks++;
      if (seen !== want) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic ta, tw, bk;
      @(posedge sys_clk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h000000, d};
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         #1 ta = awvalid && awready;
         tw = wvalid && wready;
         @(posedge sys_clk);
         if (ta) awvalid <= 0;
         if (tw) wvalid <= 0;
         #1;
      end while (awvalid || wvalid);
      do begin
         bk = bvalid;
         @(posedge sys_clk);
         #1;
      end while (!bk);
      bready <= 0;
   endtask
   task automatic rd(input logic [7:0] idx, input logic [9:0] want);
      logic t;
      exp_q.push_back(want);
      @(posedge sys_clk);
      araddr <= {idx, 2'b00};
      arvalid <= 1;
      rready <= 1;
      do begin
         #1 t = arready;
         @(posedge sys_clk);
      end while (!t);
      arvalid <= 0;
      do begin
         #1 t = rvalid;
         @(posedge sys_clk);
      end while (!t);
      rready <= 0;
   endtask
   // Read result monitor
   always @(negedge sys_clk)
      if (rvalid === 1'b1 && rready === 1'b1) chk({rresp, rdata[7:0]}, exp_q.pop_front());
   task automatic summarize();
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      #200000;
      err_total++;
      summarize();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge sys_clk);
      sys_rst <= 0;
      rd(`CSSFR_IDX_STACK, 10'h007);
      foreach (u_idx[i]) rd(u_idx[i], 10'h000);
      @(posedge sys_clk) core_req.push <= 1;
      @(posedge sys_clk) core_req.push <= 0;
      rd(`CSSFR_IDX_STACK, 10'h008);
      v = xs();
      wr(`CSSFR_IDX_PRIMARY, v);
      wr(`CSSFR_IDX_STATUS, 8'h18);
      rd(`CSSFR_IDX_STATUS, {2'b00, 8'h18 | {7'h00, ^v}});
      core_req.reg_sel <= 3'd5;
      #40 chk(core_view.work_reg_addr, {8'h00, 3'b000, 2'b11, 3'd5});
      wr(`CSSFR_IDX_MISC, 8'hFF);
      rd(`CSSFR_IDX_MISC, 10'h0BF);
      dp = xs();
      @(posedge sys_clk) core_req.ptr_load <= 1;
      core_req.ptr_val <= dp;
      @(posedge sys_clk) core_req.ptr_load <= 0;
      core_req.ptr_inc <= 1;
      @(posedge sys_clk) core_req.ptr_inc <= 0;
      rd(`CSSFR_IDX_P1_LOW, {2'b00, dp[7:0] + 8'h01});
      rd(`CSSFR_IDX_P0_HIGH, 10'h000);
      wr(`CSSFR_IDX_P1_HIGH, 8'h5A);
      #1 chk(core_view.active_ptr, {8'h5A, dp[7:0] + 8'h01});
      code_lock_in <= 1;
      wr(`CSSFR_IDX_IFCTRL, 8'hFF);
      rd(`CSSFR_IDX_IFCTRL, 10'h0CF);
      #1 chk({xmem.one_t_mode, xmem.self_prog_en, xmem.ale_enable}, 16'h0006);
      // port 2 byte while RAM disabled
      port2_latch <= xs();
      #40 chk(xmem.port2_hi, {8'h00, port2_latch});
      wr(`CSSFR_IDX_IFCTRL, 8'h04);
      #1 chk({xmem.ale_enable, xmem.one_t_mode}, 16'h0000);
      v = xs();
      wr(`CSSFR_IDX_PAGE, v);
      rd(`CSSFR_IDX_PAGE, {2'b00, v});
      rd(8'h00, {`CSSFR_RESP_SLVERR, 8'h00});
      @(posedge sys_clk) core_req.movx_ri <= 1;
      core_req.ri_val <= 8'h33;
      #40 chk(xmem.addr, {v, 8'h33});
      chk({15'h0000, xmem.xram_sel}, {15'h0000, v < 8'h04});
      @(posedge sys_clk) core_req.movx_ri <= 0;
      core_req.primary_load <= 1;
      core_req.primary_val <= 8'h07;
      @(posedge sys_clk) core_req.primary_load <= 0;
      rd(`CSSFR_IDX_STATUS, 10'h019);
      repeat (3) @(posedge sys_clk);
      summarize();
   end
endmodule
